// [common/pimap_defs.vh]
// Purpose: constants for the digital i/o process image register bank
// Assumes: word-indexed plain register port, 8-bit data
// Notes:   offsets are register indices
`ifndef PIMAP_DEFS_VH
`define PIMAP_DEFS_VH

`define ADDR_W            4
// register offsets
`define REG_IN_LOW        4'h0
`define REG_IN_HIGH       4'h1
`define REG_DISABLE_LOW   4'h2
`define REG_DISABLE_HIGH  4'h3
`define REG_SINGLE_STATUS 4'h4
`define REG_SINGLE_CTRL   4'h5
`define REG_TWO_CTRL      4'h6
`define REG_IRQ_STATUS    4'h7
`define REG_IRQ_MASK      4'h8
`define REG_DIAG          4'h9
`define REG_ANALOG_BYTES  4'hA
// field positions
`define BIT_MANUAL        0
`define BIT_CH1           0
`define BIT_CH2           1
`define IRQ_IN_LOW        0
`define IRQ_IN_HIGH       1
`define IRQ_MANUAL        2
`define IRQ_DIAG          3
// reset values
`define RST_BYTE          8'h00
`define RST_ANALOG        8'h00
// timing: input filter depth in cycles
`define SYNC_STAGES       2

`endif

// [hw/digital_io_process_image_map.v]
// Purpose: register bank mapping digital i/o channels to process images
// Assumes: 100 MHz clock, synchronous active-high reset, plain reg port
// Notes:   read data appear one cycle after the read strobe only
//
// Contract
// - disable bit 0 keeps input channel on, 1 switches it off
// - sixteen inputs: channels 1-8 low byte, 9-16 high byte
// - each output channel driven by exactly one dedicated image bit
// - diagnostic outputs give one fault bit per channel in input image
// - digital output bytes placed after all analog output data
// - single-channel output uses bit 0, bit 1 unused
// - single-channel module reports manual flag in input bit 0
// - two-channel output: bit 0 channel 1, bit 1 channel 2
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "pimap_defs.vh"
module digital_io_process_image_map (
  input  wire               clock,
  input  wire               reset,
  input  wire [`ADDR_W-1:0] address,
  input  wire [7:0]         writeData,
  input  wire               writeStrobe,
  input  wire               readStrobe,
  output reg  [7:0]         readData,
  input  wire [15:0]        fieldInputs,
  input  wire               manualMode,
  input  wire [1:0]         outputFault,
  output reg                singleOutput,
  output reg  [1:0]         twoOutputs,
  output wire [7:0]         imageOffset,
  output wire               interrupt
);

  // one-hot states of the read pipeline
  localparam ST_IDLE = 2'b01;
  localparam ST_RESP = 2'b10;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [7:0]  disableLow;
  reg  [7:0]  disableHigh;
  reg  [7:0]  singleCtrl;
  reg  [7:0]  twoCtrl;
  reg  [7:0]  irqStatus;
  reg  [7:0]  irqMask;
  reg  [7:0]  analogBytes;
  reg  [7:0]  next_readData;
  wire [15:0] syncedInputs;
  wire [15:0] activeInputs;
  wire [1:0]  syncedFault;
  wire [3:0]  events;
  wire        clearIrq;

  // decode shared by write and read paths
  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  input_sync #(.WIDTH(16)) syncIn (
    .clock (clock),
    .reset (reset),
    .din   (fieldInputs),
    .dout  (syncedInputs)
  );

  input_sync #(.WIDTH(2)) syncFault (
    .clock (clock),
    .reset (reset),
    .din   (outputFault),
    .dout  (syncedFault)
  );

  // disabled channels report zero; 1 means off
  assign activeInputs = syncedInputs & ~{disableHigh, disableLow};

  // write path; everything zero after reset so outputs start off
  always @(posedge clock)
  begin
    if (reset)
    begin
      disableLow  <= `RST_BYTE;
      disableHigh <= `RST_BYTE;
      singleCtrl  <= `RST_BYTE;
      twoCtrl     <= `RST_BYTE;
      irqMask     <= `RST_BYTE;
      analogBytes <= `RST_ANALOG;
    end
    else if (writeStrobe)
    begin
      if (hit(address, `REG_DISABLE_LOW))
        disableLow <= writeData;
      if (hit(address, `REG_DISABLE_HIGH))
        disableHigh <= writeData;
      if (hit(address, `REG_SINGLE_CTRL))
        singleCtrl <= writeData;
      if (hit(address, `REG_TWO_CTRL))
        twoCtrl <= writeData;
      if (hit(address, `REG_IRQ_MASK))
        irqMask <= writeData;
      if (hit(address, `REG_ANALOG_BYTES))
        analogBytes <= writeData;
    end
  end

  // each output channel follows exactly one image bit, others ignored
  always @(posedge clock)
  begin
    if (reset)
    begin
      singleOutput <= 1'b0;
      twoOutputs   <= 2'b00;
    end
    else
    begin
      singleOutput  <= singleCtrl[`BIT_CH1];
      twoOutputs[0] <= twoCtrl[`BIT_CH1];
      twoOutputs[1] <= twoCtrl[`BIT_CH2];
    end
  end

  // digital bytes start right after the analog output bytes
  assign imageOffset = analogBytes;

  // change events on the input image feed sticky status bits
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : evt
      wire [7:0] src;
      if (g == `IRQ_IN_LOW)
        assign src = activeInputs[7:0];
      else if (g == `IRQ_IN_HIGH)
        assign src = activeInputs[15:8];
      else if (g == `IRQ_MANUAL)
        assign src = {7'h00, manualMode};
      else
        assign src = {6'h00, syncedFault};
      edge_flag #(.WIDTH(8)) flagInst (
        .clock (clock),
        .reset (reset),
        .watch (src),
        .clear (clearIrq),
        .flag  (events[g])
      );
    end
  endgenerate

  // status read clears the latched view; edge_flag keeps set-wins
  assign clearIrq = readStrobe & hit(address, `REG_IRQ_STATUS);

  always @(posedge clock)
  begin
    if (reset)
      irqStatus <= 8'h00;
    else
      irqStatus <= {4'h0, events};
  end

  assign interrupt = |(irqStatus & irqMask);

  // read mux; unmapped addresses answer zero
  always @*
  begin
    next_readData = 8'h00;
    case (1'b1)
      hit(address, `REG_IN_LOW):
        next_readData = activeInputs[7:0];
      hit(address, `REG_IN_HIGH):
        next_readData = activeInputs[15:8];
      hit(address, `REG_DISABLE_LOW):
        next_readData = disableLow;
      hit(address, `REG_DISABLE_HIGH):
        next_readData = disableHigh;
      hit(address, `REG_SINGLE_STATUS):
        next_readData = {7'h00, manualMode};
      hit(address, `REG_SINGLE_CTRL):
        next_readData = singleCtrl;
      hit(address, `REG_TWO_CTRL):
        next_readData = twoCtrl;
      hit(address, `REG_IRQ_STATUS):
        next_readData = irqStatus;
      hit(address, `REG_IRQ_MASK):
        next_readData = irqMask;
      hit(address, `REG_DIAG):
        next_readData = {6'h00, syncedFault};
      hit(address, `REG_ANALOG_BYTES):
        next_readData = analogBytes;
      default:
        next_readData = 8'h00;
    endcase
  end

  // read answer pipeline: data valid only in cycle after strobe
  always @*
  begin
    case (state)
      ST_IDLE: next_state = readStrobe ? ST_RESP : ST_IDLE;
      ST_RESP: next_state = readStrobe ? ST_RESP : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock)
  begin
    if (reset)
    begin
      state    <= ST_IDLE;
      readData <= 8'h00;
    end
    else
    begin
      state    <= next_state;
      readData <= readStrobe ? next_readData : 8'h00;
    end
  end

endmodule

// [hw/edge_flag.v]
// Purpose: sticky event flag, set on any change of a watched vector
// Assumes: synchronous active-high reset
// Notes:   a set in the clearing cycle wins over the clear
`timescale 1ns/1ps
module edge_flag #(
  parameter WIDTH = 8
) (
  input  wire             clock,
  input  wire             reset,
  input  wire [WIDTH-1:0] watch,
  input  wire             clear,
  output reg              flag
);

  reg [WIDTH-1:0] last;

  // remember previous value and raise flag on change
  always @(posedge clock)
  begin
    if (reset)
    begin
      last <= {WIDTH{1'b0}};
      flag <= 1'b0;
    end
    else
    begin
      last <= watch;
      if (watch != last)
        flag <= 1'b1; // set beats clear so no event is lost
      else if (clear)
        flag <= 1'b0;
    end
  end

endmodule

// [hw/input_sync.v]
// Purpose: two-stage input register for field inputs
// Assumes: inputs synchronous per settings, staged for timing only
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module input_sync #(
  parameter WIDTH = 16
) (
  input  wire             clock,
  input  wire             reset,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] stage;

  // plain two-flop staging
  always @(posedge clock)
  begin
    if (reset)
    begin
      stage <= {WIDTH{1'b0}};
      dout  <= {WIDTH{1'b0}};
    end
    else
    begin
      stage <= din;
      dout  <= stage;
    end
  end

endmodule

// [testbench/controller_model.sv]
// Purpose: controller side of the register port
// Assumes: one-cycle strobes, read data in the next cycle only
// Notes:   released write data and read address carry inverted junk, not the old value
`timescale 1ns/1ps
`include "pimap_defs.vh"
module controller_model (
  input  logic               clock,
  input  logic [7:0]         readData,
  output logic [`ADDR_W-1:0] address = 'h0,
  output logic [7:0]         writeData = 8'h00,
  output logic               writeStrobe = 1'b0,
  output logic               readStrobe = 1'b0
);
  // write: one strobe cycle beside address and data
  task wr(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
    writeData <= ~d;
  endtask
  // read: data is taken in the single cycle after the strobe
  task rd(input logic [`ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    address <= ~a;
    #1 d = readData;
  endtask
endmodule

// [testbench/pimap_asserts.sv]
// Purpose: port checker for the process image register bank
// Assumes: one clock, synchronous reset, two-flop input stage
// Notes:   input reads are judged only after inputs held still
`timescale 1ns/1ps
`include "pimap_defs.vh"
module pimap_asserts (
  input logic               clock,
  input logic               reset,
  input logic [`ADDR_W-1:0] address,
  input logic [7:0]         writeData,
  input logic               writeStrobe,
  input logic               readStrobe,
  input logic [7:0]         readData,
  input logic [15:0]        fieldInputs,
  input logic               manualMode,
  input logic [1:0]         outputFault,
  input logic               singleOutput,
  input logic [1:0]         twoOutputs,
  input logic [7:0]         imageOffset,
  input logic               interrupt
);
  // slices kept as signals so that past values can be taken
  wire [7:0] loIn = fieldInputs[7:0];
  wire [7:0] hiIn = fieldInputs[15:8];
  wire [1:0] wd   = writeData[1:0];
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // a change needs two quiet cycles to cross the input stage; calm waits three
  sequence calm(s);
    $stable(s) [*3];
  endsequence
  a_out_reset: assert property ($past(reset) |->
    !singleOutput && twoOutputs == 2'b00 && !interrupt)
    else $error("outputs not clear after reset");
  a_offset_reset: assert property ($past(reset) |->
    imageOffset == 8'h00) else $error("offset not clear");
  a_read_idle: assert property (!$past(readStrobe) |->
    readData == 8'h00) else $error("read data without read");
  a_single_bit: assert property (writeStrobe &&
    address == `REG_SINGLE_CTRL |-> ##2 singleOutput == $past(wd[0], 2))
    else $error("single output not from bit 0");
  a_two_bits: assert property (writeStrobe &&
    address == `REG_TWO_CTRL |-> ##2 twoOutputs == $past(wd, 2))
    else $error("two outputs not from bits 1:0");
  a_low_inputs: assert property (calm(fieldInputs) ##0
    readStrobe && address == `REG_IN_LOW |=> !(readData & ~$past(loIn)))
    else $error("low byte shows an idle input");
  a_high_inputs: assert property (calm(fieldInputs) ##0
    readStrobe && address == `REG_IN_HIGH |=> !(readData & ~$past(hiIn)))
    else $error("high byte shows an idle input");
  a_manual_flag: assert property (calm(manualMode) ##0
    readStrobe && address == `REG_SINGLE_STATUS |=>
    readData == {7'h00, $past(manualMode)}) else $error("manual flag");
  a_fault_bits: assert property (calm(outputFault) ##0
    readStrobe && address == `REG_DIAG |=>
    readData == {6'h00, $past(outputFault)}) else $error("fault bits");
endmodule

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the process image register bank
// Assumes: 100 MHz clock, reset held 8 cycles
// Notes:   reset values first, then input rows, outputs, events and a second reset
`timescale 1ns/1ps
`include "pimap_defs.vh"
module tb_top;
  typedef struct {logic [15:0] inp; logic [7:0] dl, dh, el, eh;} row_t;
  logic               clock = 1'b0;
  logic               reset = 1'b1;
  logic [15:0]        fieldInputs = 16'h0000;
  logic               manualMode = 1'b0;
  logic [1:0]         outputFault = 2'b00;
  logic [7:0]         got;
  wire  [`ADDR_W-1:0] address;
  wire  [7:0]         writeData, readData, imageOffset;
  wire                writeStrobe, readStrobe, singleOutput, interrupt;
  wire  [1:0]         twoOutputs;
  int                 err_count = 0;
  int                 num_checks = 0;
  int                 cycles = 0;
  row_t rows[4] = '{'{16'h0201, 8'h00, 8'h00, 8'h01, 8'h02},
    '{16'h8080, 8'h00, 8'h00, 8'h80, 8'h80},
    '{16'hFFFF, 8'h0F, 8'hF0, 8'hF0, 8'h0F},
    '{16'h00FF, 8'hFF, 8'h00, 8'h00, 8'h00}};
  always #5 clock = ~clock;
  controller_model ctl (.clock, .readData, .address, .writeData,
    .writeStrobe, .readStrobe);
  digital_io_process_image_map u_digital_io_process_image_map (.clock,
    .reset, .address, .writeData, .writeStrobe, .readStrobe, .readData,
    .fieldInputs, .manualMode, .outputFault, .singleOutput, .twoOutputs,
    .imageOffset, .interrupt);
  task check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task rdchk(input string n, input logic [3:0] a, input logic [7:0] e);
    ctl.rd(a, got);
    check(n, got, e);
  endtask
  // both control bytes, then the pins two cycles later
  task outs(input logic [7:0] s, input logic [7:0] t, input logic [2:0] e);
    ctl.wr(`REG_SINGLE_CTRL, s);
    ctl.wr(`REG_TWO_CTRL, t);
    repeat (2) @(posedge clock);
    #1 check("outs", {5'h00, singleOutput, twoOutputs}, {5'h00, e});
  endtask
  task conclude;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard, far above the hundred or so cycles needed
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      conclude;
    end
  end
  initial
  begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    rdchk("disLow", `REG_DISABLE_LOW, 8'h00);
    rdchk("single", `REG_SINGLE_CTRL, 8'h00);
    foreach (rows[i])
    begin
      ctl.wr(`REG_DISABLE_LOW, rows[i].dl);
      ctl.wr(`REG_DISABLE_HIGH, rows[i].dh);
      fieldInputs <= rows[i].inp;
      repeat (3) @(posedge clock);
      rdchk("inLow", `REG_IN_LOW, rows[i].el);
      rdchk("inHigh", `REG_IN_HIGH, rows[i].eh);
    end
    outs(8'h02, 8'hFD, 3'b001);
    outs(8'h01, 8'h02, 3'b110);
    // unmask manual and fault events, drop the input events
    ctl.wr(`REG_IRQ_MASK, 8'h0C);
    ctl.rd(`REG_IRQ_STATUS, got);
    manualMode <= 1'b1;
    outputFault <= 2'b10;
    repeat (4) @(posedge clock);
    #1 check("irqUp", {7'h00, interrupt}, 8'h01);
    rdchk("manual", `REG_SINGLE_STATUS, 8'h01);
    rdchk("diag", `REG_DIAG, 8'h02);
    rdchk("irqStat", `REG_IRQ_STATUS, 8'h0C);
    // the clear lands on the strobe edge; the status copy follows one later
    @(posedge clock);
    #1 check("irqDown", {7'h00, interrupt}, 8'h00);
    ctl.wr(`REG_IRQ_MASK, 8'h00);
    manualMode <= 1'b0;
    repeat (4) @(posedge clock);
    #1 check("irqMask", {7'h00, interrupt}, 8'h00);
    rdchk("irqSticky", `REG_IRQ_STATUS, 8'h04);
    ctl.wr(`REG_ANALOG_BYTES, 8'h03);
    #1 check("offset", imageOffset, 8'h03);
    rdchk("unmapped", 4'hF, 8'h00);
    // second reset in mid-run must clear outputs again
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    outs(8'h00, 8'h00, 3'b000);
    check("offsetRst", imageOffset, 8'h00);
    conclude;
  end
endmodule
bind digital_io_process_image_map pimap_asserts u_chk (.clock, .reset,
  .address, .writeData, .writeStrobe, .readStrobe, .readData,
  .fieldInputs, .manualMode, .outputFault, .singleOutput, .twoOutputs,
  .imageOffset, .interrupt);
